// File: rtl/fdx_chain_ctrl.sv
// Function
// R1 - daisy chain: first device select held low
// R2 - all other devices select held high
// R3 - write token out feeds next write token in
// R4 - read token out feeds next read token in
// R5 - one shared offset load line
// R6 - half full unavailable in daisy chain
// R7 - composite flags ORed; almost flags approximate
// R8 - daisy devices: single-buffered, async partial flags
// R9 - series: data out feeds next data in
// R10 - series chain acts as one summed FIFO
// R11 - series: fall-through selected at master reset
// R12 - read clocks run continuously
// R13 - word present drives output ready low
// R14 - first word ripple equals summed delays
// R15 - only first word sees ripple delay
// R16 - freed slot drives input ready low
// R17 - bubble-up delay equals summed delays
// R18 - transfer clock from faster of write/read
// R19 - width: never tie device outputs together
// R20 - single-device straps sampled at reset
// R21 - width: gate empty flags, gate full flags
// R22 - series: ready lines drive neighbour enables
`timescale 1ns/1ps
module fdx_chain_ctrl #(
   parameter int N_DEV = 3,
   parameter int DATA_W = 18,
   parameter int WCLK_HALF = 1,
   parameter int RCLK_HALF = 1
) (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [1:0] MODE,
   input wire logic START,
   output logic BUSY,
   input wire logic WR_VALID,
   input wire logic [DATA_W-1:0] WR_DATA,
   output logic WR_READY,
   input wire logic RD_REQ,
   output logic RD_VALID,
   output logic [DATA_W-1:0] RD_DATA,
   output logic EMPTY,
   output logic FULL,
   output logic ALMOST_EMPTY,
   output logic ALMOST_FULL,
   output logic HALF_FULL,
   output logic DEV_MRS_N,
   output logic DEV_FALL_THROUGH_MODE,
   output logic DEV_OFFSET_LOAD_N,
   output logic [N_DEV-1:0] DEV_FIRST_IN_CHAIN_SELECT,
   output logic [N_DEV-1:0] DEV_WRITE_TOKEN_IN,
   output logic [N_DEV-1:0] DEV_READ_TOKEN_IN,
   input wire logic [N_DEV-1:0] DEV_WRITE_TOKEN_OUT,
   input wire logic [N_DEV-1:0] DEV_READ_TOKEN_OUT,
   output logic DEV_WCLK,
   output logic DEV_RCLK,
   output logic DEV_XFER_CLK,
   output logic [N_DEV-1:0] DEV_WEN_N,
   output logic [N_DEV-1:0] DEV_REN_N,
   output logic [DATA_W-1:0] DEV_D,
   input wire logic [DATA_W-1:0] DEV_Q,
   input wire logic [N_DEV-1:0] DEV_EMPTY_FLAG_N,
   input wire logic [N_DEV-1:0] DEV_FULL_FLAG_N,
   input wire logic [N_DEV-1:0] DEV_ALMOST_EMPTY_FLAG_N,
   input wire logic [N_DEV-1:0] DEV_ALMOST_FULL_FLAG_N,
   input wire logic [N_DEV-1:0] DEV_HALF_FULL_FLAG_N
);

   localparam bit XFER_FROM_W = (WCLK_HALF <= RCLK_HALF);

   fdx_pkg::fdx_state_type state_q;
   fdx_pkg::fdx_mode_type mode_q;
   logic [fdx_pkg::SEQ_CNT_W-1:0] seq_cnt_q;
   logic w_clk, w_fall;
   logic r_clk, r_fall;
   logic x_fall;
   logic ef_any, ef_all, ff_any, ff_all;
   logic pae_any, pae_all, paf_any, paf_all;
   logic running, fall_through_mode, series;
   logic avail, room;
   logic wr_take, rd_take;
   logic rd_pend_q;

   // device clocks; the read clock never stops
   fdx_clk_div #(.HALF(WCLK_HALF)) u_wdiv (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .clk_out(w_clk),
      .rise_tick(),
      .fall_tick(w_fall)
   );

   fdx_clk_div #(.HALF(RCLK_HALF)) u_rdiv (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .clk_out(r_clk),
      .rise_tick(),
      .fall_tick(r_fall)
   ); // see R12

   assign DEV_WCLK = w_clk;
   assign DEV_RCLK = r_clk;
   assign DEV_XFER_CLK = XFER_FROM_W ? w_clk : r_clk; // see R18
   assign x_fall = XFER_FROM_W ? w_fall : r_fall;

   fdx_flag_combine #(.N(N_DEV)) u_ef (
      .flags(DEV_EMPTY_FLAG_N),
      .any_high(ef_any),
      .all_high(ef_all)
   );

   fdx_flag_combine #(.N(N_DEV)) u_ff (
      .flags(DEV_FULL_FLAG_N),
      .any_high(ff_any),
      .all_high(ff_all)
   );

   fdx_flag_combine #(.N(N_DEV)) u_pae (
      .flags(DEV_ALMOST_EMPTY_FLAG_N),
      .any_high(pae_any),
      .all_high(pae_all)
   );

   fdx_flag_combine #(.N(N_DEV)) u_paf (
      .flags(DEV_ALMOST_FULL_FLAG_N),
      .any_high(paf_any),
      .all_high(paf_all)
   );

   assign running = (state_q == fdx_pkg::ST_RUN);
   assign series = (mode_q == fdx_pkg::MODE_SERIES);
   assign fall_through_mode = series;

   // word available at the read end, room at the write end
   always_comb begin
      unique case (mode_q)
         fdx_pkg::MODE_SINGLE: begin
            avail = DEV_EMPTY_FLAG_N[0];
            room = DEV_FULL_FLAG_N[0];
         end
         fdx_pkg::MODE_WIDTH: begin
            avail = ef_all; // see R21
            room = ff_all; // see R21
         end
         fdx_pkg::MODE_DAISY: begin
            avail = ef_any; // see R7
            room = ff_any; // see R7
         end
         fdx_pkg::MODE_SERIES: begin
            avail = ~DEV_EMPTY_FLAG_N[N_DEV-1]; // see R13
            room = ~DEV_FULL_FLAG_N[0]; // see R16
         end
      endcase
   end

   assign wr_take = running & w_fall & WR_VALID & room;
   assign rd_take = running & r_fall & RD_REQ & avail;

   // master reset sequencer
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= fdx_pkg::ST_IDLE;
         mode_q <= fdx_pkg::MODE_SINGLE;
         seq_cnt_q <= '0;
      end else begin
         unique case (state_q)
            fdx_pkg::ST_IDLE, fdx_pkg::ST_RUN: begin
               if (START) begin
                  state_q <= fdx_pkg::ST_RESET;
                  mode_q <= fdx_pkg::fdx_mode_type'(MODE);
                  seq_cnt_q <= fdx_pkg::SEQ_CNT_W'(fdx_pkg::RESET_HOLD_CYC - 1);
               end
            end
            fdx_pkg::ST_RESET: begin
               if (seq_cnt_q == '0) begin
                  state_q <= fdx_pkg::ST_SETTLE;
                  seq_cnt_q <= fdx_pkg::SEQ_CNT_W'(fdx_pkg::SETTLE_CYC - 1);
               end else begin
                  seq_cnt_q <= seq_cnt_q - 1'h1;
               end
            end
            fdx_pkg::ST_SETTLE: begin
               if (seq_cnt_q == '0) begin
                  state_q <= fdx_pkg::ST_RUN;
               end else begin
                  seq_cnt_q <= seq_cnt_q - 1'h1;
               end
            end
            default: begin
               state_q <= fdx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // reset line, mode pin and shared offset load
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEV_MRS_N <= 1'h0;
         DEV_FALL_THROUGH_MODE <= 1'h0;
         DEV_OFFSET_LOAD_N <= fdx_pkg::RST_OFFSET_LOAD_N;
         BUSY <= 1'h1;
      end else begin
         DEV_MRS_N <= (state_q != fdx_pkg::ST_RESET);
         DEV_FALL_THROUGH_MODE <= series; // see R11
         DEV_OFFSET_LOAD_N <= fdx_pkg::RST_OFFSET_LOAD_N; // see R5
         BUSY <= ~running;
      end
   end

   // straps and token routing
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEV_FIRST_IN_CHAIN_SELECT <= '0;
         DEV_WRITE_TOKEN_IN <= '0;
         DEV_READ_TOKEN_IN <= '0;
      end else begin
         for (int i = 0; i < N_DEV; i++) begin
            if (mode_q == fdx_pkg::MODE_DAISY) begin
               DEV_FIRST_IN_CHAIN_SELECT[i] <= (i != 0); // see R1 R2
               DEV_WRITE_TOKEN_IN[i] <= DEV_WRITE_TOKEN_OUT[(i + N_DEV - 1) % N_DEV]; // see R3
               DEV_READ_TOKEN_IN[i] <= DEV_READ_TOKEN_OUT[(i + N_DEV - 1) % N_DEV]; // see R4
            end else begin
               DEV_FIRST_IN_CHAIN_SELECT[i] <= fdx_pkg::STRAP_SINGLE[2]; // see R20
               DEV_READ_TOKEN_IN[i] <= fdx_pkg::STRAP_SINGLE[1]; // see R20
               DEV_WRITE_TOKEN_IN[i] <= fdx_pkg::STRAP_SINGLE[0]; // see R20
            end
         end
      end
   end

   // write enables: user word at the head, ready lines inside a series chain
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEV_WEN_N <= {N_DEV{fdx_pkg::RST_ENABLE_N}};
      end else begin
         for (int i = 0; i < N_DEV; i++) begin
            if (!running) begin
               DEV_WEN_N[i] <= fdx_pkg::RST_ENABLE_N;
            end else if (series && i != 0) begin
               if (x_fall) begin
                  DEV_WEN_N[i] <= DEV_EMPTY_FLAG_N[i-1]; // see R22 R13 R14
               end
            end else if (mode_q == fdx_pkg::MODE_SINGLE && i != 0) begin
               DEV_WEN_N[i] <= fdx_pkg::RST_ENABLE_N;
            end else if (w_fall) begin
               DEV_WEN_N[i] <= ~(WR_VALID & room);
            end
         end
      end
   end

   // read enables: user request at the tail, ready lines inside a series chain
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEV_REN_N <= {N_DEV{fdx_pkg::RST_ENABLE_N}};
      end else begin
         for (int i = 0; i < N_DEV; i++) begin
            if (!running) begin
               DEV_REN_N[i] <= fdx_pkg::RST_ENABLE_N;
            end else if (series && i != N_DEV - 1) begin
               if (x_fall) begin
                  DEV_REN_N[i] <= DEV_FULL_FLAG_N[i+1]; // see R22 R16 R17
               end
            end else if (mode_q == fdx_pkg::MODE_SINGLE && i != 0) begin
               DEV_REN_N[i] <= fdx_pkg::RST_ENABLE_N;
            end else if (r_fall) begin
               DEV_REN_N[i] <= ~(RD_REQ & avail);
            end
         end
      end
   end

   // write data, one word per write clock
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DEV_D <= '0;
         WR_READY <= 1'h0;
      end else begin
         WR_READY <= wr_take;
         if (wr_take) begin
            DEV_D <= WR_DATA; // see R9 R10
         end
      end
   end

   // read data: fall-through shows the word before the read, standard after
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rd_pend_q <= 1'h0;
         RD_VALID <= 1'h0;
         RD_DATA <= '0;
      end else begin
         RD_VALID <= 1'h0;
         if (r_fall) begin
            rd_pend_q <= rd_take & ~fall_through_mode;
         end
         if (fall_through_mode && rd_take) begin
            RD_DATA <= DEV_Q; // see R15
            RD_VALID <= 1'h1;
         end else if (!fall_through_mode && r_fall && rd_pend_q) begin
            RD_DATA <= DEV_Q;
            RD_VALID <= 1'h1;
         end
      end
   end

   // composite status
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         EMPTY <= 1'h1;
         FULL <= 1'h0;
         ALMOST_EMPTY <= 1'h1;
         ALMOST_FULL <= 1'h0;
         HALF_FULL <= 1'h0;
      end else begin
         EMPTY <= ~avail;
         FULL <= ~room;
         unique case (mode_q)
            fdx_pkg::MODE_DAISY: begin
               ALMOST_EMPTY <= ~pae_any; // see R7 R8
               ALMOST_FULL <= ~paf_any; // see R7 R8
               HALF_FULL <= 1'h0; // see R6
            end
            fdx_pkg::MODE_SERIES: begin
               ALMOST_EMPTY <= ~DEV_ALMOST_EMPTY_FLAG_N[N_DEV-1];
               ALMOST_FULL <= ~DEV_ALMOST_FULL_FLAG_N[0];
               HALF_FULL <= ~DEV_HALF_FULL_FLAG_N[0];
            end
            fdx_pkg::MODE_WIDTH: begin
               ALMOST_EMPTY <= ~pae_all; // see R19
               ALMOST_FULL <= ~paf_all;
               HALF_FULL <= ~DEV_HALF_FULL_FLAG_N[0];
            end
            fdx_pkg::MODE_SINGLE: begin
               ALMOST_EMPTY <= ~DEV_ALMOST_EMPTY_FLAG_N[0];
               ALMOST_FULL <= ~DEV_ALMOST_FULL_FLAG_N[0];
               HALF_FULL <= ~DEV_HALF_FULL_FLAG_N[0];
            end
         endcase
      end
   end

endmodule // fdx_chain_ctrl

// File: pkg/fdx_pkg.sv
package fdx_pkg;

   // controller sequencing states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_RESET  = 4'h2,
      ST_SETTLE = 4'h4,
      ST_RUN    = 4'h8
   } fdx_state_type;

   // how the attached devices are wired
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_WIDTH  = 2'h1,
      MODE_DAISY  = 2'h2,
      MODE_SERIES = 2'h3
   } fdx_mode_type;

   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_HOLD_NS = 1000;
   localparam int SETTLE_NS = 500;
   // least times, rounded up to whole cycles
   localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEQ_CNT_W = 8;
   localparam int DIV_CNT_W = 8;

   // strap order is first_in_chain_select, read_token_in, write_token_in
   localparam logic [2:0] STRAP_SINGLE = 3'h0;
   localparam logic RST_OFFSET_LOAD_N = 1'h1;
   localparam logic RST_ENABLE_N = 1'h1;

endpackage

// File: rtl/fdx_clk_div.sv
`timescale 1ns/1ps
module fdx_clk_div #(
   parameter int HALF = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic clk_out,
   output logic rise_tick,
   output logic fall_tick
);

   logic [fdx_pkg::DIV_CNT_W-1:0] cnt_q;
   logic wrap;

   assign wrap = (cnt_q == fdx_pkg::DIV_CNT_W'(HALF - 1));
   assign rise_tick = wrap & ~clk_out;
   assign fall_tick = wrap & clk_out;

   // free-running, never gated
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         clk_out <= 1'h0;
      end else if (wrap) begin
         cnt_q <= '0;
         clk_out <= ~clk_out;
      end else begin
         cnt_q <= cnt_q + 1'h1;
      end
   end

endmodule // fdx_clk_div

// File: rtl/fdx_flag_combine.sv
`timescale 1ns/1ps
module fdx_flag_combine #(
   parameter int N = 3
) (
   input wire logic [N-1:0] flags,
   output logic any_high,
   output logic all_high
);

   assign any_high = |flags;
   assign all_high = &flags;

endmodule // fdx_flag_combine

// File: bench/fdx_chk_assertions.sv
`timescale 1ns/1ps
module fdx_chk #(
   parameter int N_DEV = 3,
   parameter int DATA_W = 18
) (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic START,
   input wire logic BUSY,
   input wire logic [DATA_W-1:0] WR_DATA,
   input wire logic WR_READY,
   input wire logic HALF_FULL,
   input wire logic DEV_MRS_N,
   input wire logic DEV_FALL_THROUGH_MODE,
   input wire logic DEV_OFFSET_LOAD_N,
   input wire logic [N_DEV-1:0] DEV_FIRST_IN_CHAIN_SELECT,
   input wire logic [N_DEV-1:0] DEV_WRITE_TOKEN_IN,
   input wire logic [N_DEV-1:0] DEV_READ_TOKEN_IN,
   input wire logic [N_DEV-1:0] DEV_WRITE_TOKEN_OUT,
   input wire logic [N_DEV-1:0] DEV_READ_TOKEN_OUT,
   input wire logic [N_DEV-1:0] DEV_WEN_N,
   input wire logic [DATA_W-1:0] DEV_D
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   logic daisy;
   assign daisy = DEV_FIRST_IN_CHAIN_SELECT == {{(N_DEV-1){1'b1}}, 1'b0};
   AST_LOAD_HIGH: assert property (DEV_OFFSET_LOAD_N)
      else $error("offset load not high");
   AST_STRAPS: assert property (|DEV_FIRST_IN_CHAIN_SELECT |-> daisy)
      else $error("bad first select pattern");
   AST_WTOKEN: assert property (daisy && $past(daisy) |->
      DEV_WRITE_TOKEN_IN == $past({DEV_WRITE_TOKEN_OUT[N_DEV-2:0], DEV_WRITE_TOKEN_OUT[N_DEV-1]}))
      else $error("write token not passed on");
   AST_RTOKEN: assert property (daisy && $past(daisy) |->
      DEV_READ_TOKEN_IN == $past({DEV_READ_TOKEN_OUT[N_DEV-2:0], DEV_READ_TOKEN_OUT[N_DEV-1]}))
      else $error("read token not passed on");
   AST_NO_HALF: assert property (daisy && $past(daisy) |-> !HALF_FULL)
      else $error("half full shown in chain");
   AST_ALONE: assert property (DEV_FIRST_IN_CHAIN_SELECT == '0 && $past(DEV_FIRST_IN_CHAIN_SELECT) == '0
      |-> DEV_WRITE_TOKEN_IN == '0 && DEV_READ_TOKEN_IN == '0)
      else $error("tokens in standalone");
   AST_FT_STRAPS: assert property (DEV_FALL_THROUGH_MODE |-> DEV_FIRST_IN_CHAIN_SELECT == '0)
      else $error("fall through with chain straps");
   AST_MRS_HOLD: assert property (START |=> ##[0:2] (!DEV_MRS_N) [*8])
      else $error("master reset too short");
   AST_WR_TAKE: assert property (WR_READY |-> !BUSY && DEV_WEN_N != '1 && DEV_D == $past(WR_DATA)
      ##1 !WR_READY)
      else $error("write handoff wrong");
endmodule // fdx_chk
bind fdx_chain_ctrl fdx_chk #(.N_DEV(N_DEV), .DATA_W(DATA_W)) i_chk (.*);

// File: bench/fdx_dev_model.sv
`timescale 1ns/1ps
module fdx_dev_model #(
   parameter int N_DEV = 3,
   parameter int DATA_W = 18,
   parameter int DEPTH = 4
) (
   input wire logic DEV_MRS_N,
   input wire logic DEV_FALL_THROUGH_MODE,
   input wire logic [N_DEV-1:0] DEV_FIRST_IN_CHAIN_SELECT,
   input wire logic DEV_WCLK,
   input wire logic DEV_RCLK,
   input wire logic [N_DEV-1:0] DEV_WEN_N,
   input wire logic [N_DEV-1:0] DEV_REN_N,
   input wire logic [DATA_W-1:0] DEV_D,
   output logic [DATA_W-1:0] DEV_Q,
   output logic [N_DEV-1:0] DEV_WRITE_TOKEN_OUT,
   output logic [N_DEV-1:0] DEV_READ_TOKEN_OUT,
   output logic [N_DEV-1:0] DEV_EMPTY_FLAG_N,
   output logic [N_DEV-1:0] DEV_FULL_FLAG_N,
   output logic [N_DEV-1:0] DEV_ALMOST_EMPTY_FLAG_N,
   output logic [N_DEV-1:0] DEV_ALMOST_FULL_FLAG_N,
   output logic [N_DEV-1:0] DEV_HALF_FULL_FLAG_N
);
   localparam int CAP = N_DEV * DEPTH;
   logic [DATA_W-1:0] mem [CAP];
   logic [DATA_W-1:0] q_std;
   logic ft, wr, rd, mt, fl;
   int wp, rp, cnt;
   assign ft = DEV_FALL_THROUGH_MODE;
   assign wr = ft ? !DEV_WEN_N[0] : DEV_WEN_N != '1;
   assign rd = ft ? !DEV_REN_N[N_DEV-1] : DEV_REN_N != '1;
   assign cnt = wp - rp;
   always @(posedge DEV_WCLK or negedge DEV_MRS_N) begin
      if (!DEV_MRS_N) wp <= 0;
      else if (wr && cnt < CAP) begin
         mem[wp % CAP] <= DEV_D;
         wp <= wp + 1;
      end
   end
   always @(posedge DEV_RCLK or negedge DEV_MRS_N) begin
      if (!DEV_MRS_N) rp <= 0;
      else if (rd && cnt > 0) begin
         q_std <= mem[rp % CAP];
         rp <= rp + 1;
      end
   end
   // head shows at once in fall-through, garbage when empty
   assign DEV_Q = !ft ? q_std : (cnt > 0 ? mem[rp % CAP] : ~DEV_D);
   assign mt = cnt == 0;
   assign fl = cnt >= CAP;
   assign DEV_EMPTY_FLAG_N = {N_DEV{ft ? mt : !mt}};
   assign DEV_FULL_FLAG_N = {N_DEV{ft ? fl : !fl}};
   assign DEV_ALMOST_EMPTY_FLAG_N = {N_DEV{cnt > 1}};
   assign DEV_ALMOST_FULL_FLAG_N = {N_DEV{cnt < CAP - 1}};
   assign DEV_HALF_FULL_FLAG_N = DEV_FIRST_IN_CHAIN_SELECT != '0 ? '1 : {N_DEV{cnt <= CAP / 2}};
   assign DEV_WRITE_TOKEN_OUT = DEV_FIRST_IN_CHAIN_SELECT == '0 ? '0 : wp[N_DEV-1:0];
   assign DEV_READ_TOKEN_OUT = DEV_FIRST_IN_CHAIN_SELECT == '0 ? '0 : rp[N_DEV-1:0];
endmodule // fdx_dev_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int N_DEV = 3;
   localparam int DATA_W = 18;
   localparam int CAP = N_DEV * 4;
   logic CLOCK = 0, RESET_N = 0, START = 0, WR_VALID = 0, RD_REQ = 0;
   logic [1:0] MODE = '0;
   logic [DATA_W-1:0] WR_DATA = '0;
   logic BUSY, WR_READY, RD_VALID, EMPTY, FULL, ALMOST_EMPTY, ALMOST_FULL, HALF_FULL;
   logic DEV_MRS_N, DEV_FALL_THROUGH_MODE, DEV_OFFSET_LOAD_N, DEV_WCLK, DEV_RCLK, DEV_XFER_CLK;
   logic [DATA_W-1:0] RD_DATA, DEV_D, DEV_Q;
   logic [N_DEV-1:0] DEV_FIRST_IN_CHAIN_SELECT, DEV_WRITE_TOKEN_IN, DEV_READ_TOKEN_IN;
   logic [N_DEV-1:0] DEV_WRITE_TOKEN_OUT, DEV_READ_TOKEN_OUT, DEV_WEN_N, DEV_REN_N;
   logic [N_DEV-1:0] DEV_EMPTY_FLAG_N, DEV_FULL_FLAG_N, DEV_HALF_FULL_FLAG_N;
   logic [N_DEV-1:0] DEV_ALMOST_EMPTY_FLAG_N, DEV_ALMOST_FULL_FLAG_N;
   logic [DATA_W-1:0] exp_q [$];
   logic wr_s, bs;
   int errors = 0, n_checks = 0;
   fdx_chain_ctrl #(.N_DEV(N_DEV), .DATA_W(DATA_W), .WCLK_HALF(1), .RCLK_HALF(2)) i_dut (.*);
   fdx_dev_model #(.N_DEV(N_DEV), .DATA_W(DATA_W)) i_dev (.*);
   always #50 CLOCK = ~CLOCK;
   task automatic cmp_data(input logic [DATA_W-1:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t data %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // settled samples, then the oldest note is compared
   always @(negedge CLOCK) begin
      wr_s = WR_READY;
      bs = BUSY;
      if (RESET_N) cmp_flag(DEV_XFER_CLK, DEV_WCLK, "transfer clock");
      if (RD_VALID === 1'b1) begin
         if (exp_q.size() == 0) cmp_flag(1'b0, 1'b1, "extra word");
         else cmp_data(RD_DATA, exp_q.pop_front());
      end else if (RESET_N && RD_VALID !== 1'b0) begin
         cmp_flag(1'b0, 1'b1, "read valid unknown");
      end
   end
   task automatic put(input logic [DATA_W-1:0] d);
      int t = 0;
      WR_VALID <= 1'b1;
      WR_DATA <= d;
      do begin @(posedge CLOCK); t++; end while (wr_s !== 1'b1 && t < 50);
      if (t < 50) exp_q.push_back(d);
      else cmp_flag(1'b0, 1'b1, "write stuck");
   endtask
   task automatic run_mode(input logic [1:0] m);
      int t = 0;
      MODE <= m;
      START <= 1'b1;
      @(posedge CLOCK) START <= 1'b0;
      do begin @(posedge CLOCK); t++; end while ((bs !== 1'b0 || t < 3) && t < 100);
      cmp_flag(DEV_FALL_THROUGH_MODE, m == 2'h3, "ft pin");
      cmp_flag(DEV_OFFSET_LOAD_N, 1'b1, "load pin");
      cmp_flag(DEV_FIRST_IN_CHAIN_SELECT[0], 1'b0, "first select");
      cmp_flag(&DEV_FIRST_IN_CHAIN_SELECT[N_DEV-1:1], m == 2'h2, "other select");
      for (int i = 0; i < CAP; i++) put(DATA_W'($urandom()));
      t = 0;
      repeat (20) begin @(posedge CLOCK); t += wr_s; end
      WR_VALID <= 1'b0;
      cmp_flag(t == 0, 1'b1, "overfill");
      cmp_flag(FULL, 1'b1, "full");
      cmp_flag(ALMOST_FULL, 1'b1, "almost full");
      cmp_flag(HALF_FULL, m != 2'h2, "half full");
      if (m == 2'h3) cmp_flag(DEV_WEN_N[N_DEV-1:1] == '0 && DEV_REN_N[N_DEV-2:0] == '1, 1'b1, "chain full");
      RD_REQ <= 1'b1;
      t = 0;
      while (exp_q.size() != 0 && t < 400) begin @(posedge CLOCK); t++; end
      RD_REQ <= 1'b0;
      repeat (10) @(posedge CLOCK);
      cmp_flag(exp_q.size() == 0, 1'b1, "drain");
      cmp_flag(EMPTY, 1'b1, "empty");
      if (m == 2'h3) cmp_flag(DEV_WEN_N[N_DEV-1:1] == '1 && DEV_REN_N[N_DEV-2:0] == '0, 1'b1, "chain empty");
      cmp_flag(ALMOST_EMPTY, 1'b1, "almost empty");
   endtask
   initial begin
      void'($urandom(90));
      repeat (12) @(posedge CLOCK);
      RESET_N <= 1'b1;
      @(posedge CLOCK);
      for (int m = 0; m < 4; m++) run_mode(2'(m));
      tally_and_finish;
   end
   initial begin
      #(20000 * 100);
      errors++;
      tally_and_finish;
   end
endmodule // tb_top
